// File: src/bank_lock_pkg.sv
package bank_lock_pkg;

    localparam int NUM_BANKS_DEF  = 16;
    localparam int NUM_BLOCKS_DEF = 64;
    localparam int BANK_BITS      = 4;
    localparam int BLOCK_BITS     = 6;
    localparam logic [BANK_BITS-1:0] PARAM_BANK_DEF = 4'hF;
    localparam logic [BLOCK_BITS-1:0] PARAM_BLK_FIRST_DEF = 6'h3C;

    localparam logic PROTECT_RESET = 1'b1;
    localparam logic [BANK_BITS-1:0] BANK_RESET = 4'h0;
    localparam logic [BLOCK_BITS-1:0] BLOCK_RESET = 6'h00;

    // Operation-done pulses needed to finish one op
    localparam int DONE_COUNT = 1;

    typedef enum logic [3:0] {
        CMD_READ_ARRAY,
        CMD_READ_STATUS,
        CMD_READ_QUERY,
        CMD_READ_SIGNATURE,
        CMD_PROGRAM,
        CMD_ERASE,
        CMD_SUSPEND,
        CMD_RESUME,
        CMD_PROTECT,
        CMD_UNPROTECT,
        CMD_PROG_SETUP,
        CMD_ERASE_SETUP,
        CMD_OTP_PROGRAM
    } cmd_e;

    typedef enum logic [1:0] {
        SPACE_ARRAY,
        SPACE_QUERY,
        SPACE_OTP,
        SPACE_SIGNATURE
    } space_e;

    typedef struct packed {
        cmd_e                  cmd;
        space_e                space;
        logic [BANK_BITS-1:0]  bank;
        logic [BLOCK_BITS-1:0] block;
        logic [15:0]           word;
    } cmd_s;

    typedef struct packed {
        logic accepted;
        logic refused;
        logic protect_error;
        logic read_valid;
        logic protect_status_line;
    } resp_s;

endpackage

// File: src/bank_lock.sv
// What this block does
// [RULE_01] Only one bank may be programming or erasing at any time.
// [RULE_02] Reads to other banks are served while one bank is busy.
// [RULE_03] Suspend of an ongoing program or erase is accepted; code refuses it for a program started in erase suspend.
// [RULE_04] In erase suspend, program to another block is accepted.
// [RULE_05] Reads to other banks allowed between setup and confirm cycles.
// [RULE_06] Parameter bank never runs concurrently with query, OTP, signature.
// [RULE_07] Other-bank command set follows the busy bank's state.
// [RULE_08] Busy bank accepts read array, status, query, signature, suspend.
// [RULE_09] Suspended bank reads barred from suspended block or word.
// [RULE_10] Same bank: program only in erase suspend; never erase when busy.
// [RULE_11] Parameter block busy: bars query, OTP, signature, param-bank reads.
// [RULE_12] OTP programming bars all reads; main programming bars same bank.
// [RULE_13] Per-block protect bit plus supply lockout forbid program, erase.
// [RULE_14] Protect changes take effect on the very next cycle.
// [RULE_15] Signature-mode read returns the block protect bit on data line.
// [RULE_16] Reset sets every block protected.
// [RULE_17] Program or erase to protected block is refused with an error.
// [RULE_18] Unprotected blocks accept program and erase; reset re-protects.
// [RULE_19] Protect and unprotect accepted during erase suspend.
// [RULE_20] Host suspends, polls, changes protection, then resumes erase.
// [RULE_21] Erase suspended on a now-protected block still completes.
// [RULE_22] No protect or unprotect while a program is suspended.
// [RULE_23] Refused commands change no bank state and no protect bit.
`timescale 1ns/100ps
module bank_lock #(
    parameter int NUM_BLOCKS = bank_lock_pkg::NUM_BLOCKS_DEF,
    parameter logic [bank_lock_pkg::BANK_BITS-1:0] PARAM_BANK =
        bank_lock_pkg::PARAM_BANK_DEF,
    parameter logic [bank_lock_pkg::BLOCK_BITS-1:0] PARAM_BLK_FIRST =
        bank_lock_pkg::PARAM_BLK_FIRST_DEF
) (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                sys_rst,
    // Command port
    input  wire logic                cmd_valid,
    input  wire bank_lock_pkg::cmd_s cmd_in,
    // Array engine
    input  wire logic                op_done,
    input  wire logic                program_supply_lockout_level,
    // Answer
    output bank_lock_pkg::resp_s     resp,
    output logic                     prog_busy,
    output logic                     erase_busy,
    output logic                     prog_susp,
    output logic                     erase_susp
);

    localparam int BB = bank_lock_pkg::BANK_BITS;
    localparam int KB = bank_lock_pkg::BLOCK_BITS;

    ////////////////////////////////////////////////////////////////////////
    // Supply lockout pin synchroniser

    logic [2:0] lock_sync_q;
    logic       lock_q;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            lock_sync_q <= 3'h7;
            lock_q      <= 1'b1;
        end
        else
        begin
            lock_sync_q <= {lock_sync_q[1:0], program_supply_lockout_level};
            if (lock_sync_q[2] == lock_sync_q[1])
                lock_q <= lock_sync_q[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Operation state

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PROG,
        ST_ERASE,
        ST_PROG_SUSP,
        ST_ERASE_SUSP,
        ST_PROG_IN_ESUSP
    } op_e;

    op_e            st_q;
    op_e            st_d;
    logic [BB-1:0]  op_bank_q;
    logic [KB-1:0]  op_block_q;
    logic [15:0]    op_word_q;
    logic           op_otp_q;
    logic [BB-1:0]  es_bank_q;
    logic [KB-1:0]  es_block_q;
    logic [NUM_BLOCKS-1:0] prot_q;

    bank_lock_pkg::cmd_s c;
    assign c = cmd_in;

    wire same_bank  = (c.bank == op_bank_q);
    wire es_bank_eq = (c.bank == es_bank_q);
    wire tgt_pbank  = (c.bank == PARAM_BANK);
    wire op_param   = (op_block_q >= PARAM_BLK_FIRST);
    wire op_pbank   = (op_bank_q == PARAM_BANK);
    wire running    = (st_q == ST_PROG) || (st_q == ST_ERASE)
                   || (st_q == ST_PROG_IN_ESUSP);
    wire is_read    = (c.cmd == bank_lock_pkg::CMD_READ_ARRAY)
                   || (c.cmd == bank_lock_pkg::CMD_READ_STATUS)
                   || (c.cmd == bank_lock_pkg::CMD_READ_QUERY)
                   || (c.cmd == bank_lock_pkg::CMD_READ_SIGNATURE);
    wire special    = (c.space != bank_lock_pkg::SPACE_ARRAY);
    wire is_arr_rd  = (c.cmd == bank_lock_pkg::CMD_READ_ARRAY) && !special;
    wire is_write   = (c.cmd == bank_lock_pkg::CMD_PROGRAM)
                   || (c.cmd == bank_lock_pkg::CMD_ERASE)
                   || (c.cmd == bank_lock_pkg::CMD_OTP_PROGRAM);
    wire blk_prot   = prot_q[c.block];

    // Read conflicts with the running or suspended operation
    wire rd_block_otp   = running && op_otp_q;                 // RULE_12
    wire rd_block_param = running && op_param && op_pbank &&
                          (special || (tgt_pbank && is_arr_rd)); // RULE_11
    wire rd_block_mpb   = running && !op_param && op_pbank &&
                          is_arr_rd && tgt_pbank;              // RULE_12
    wire rd_block_6     = running && op_pbank && special;      // RULE_06
    wire rd_susp_blk    = (st_q == ST_ERASE_SUSP ||
                           st_q == ST_PROG_IN_ESUSP) && is_arr_rd &&
                          es_bank_eq && (c.block == es_block_q); // RULE_09
    wire rd_susp_word   = (st_q == ST_PROG_SUSP) && is_arr_rd &&
                          same_bank && (c.block == op_block_q) &&
                          (c.word == op_word_q);               // RULE_09
    wire rd_ok = !(rd_block_otp || rd_block_param || rd_block_mpb ||
                   rd_block_6 || rd_susp_blk ||
                   rd_susp_word);                              // RULE_02

    // Program/erase admission
    wire prot_hit = is_write && (c.cmd != bank_lock_pkg::CMD_OTP_PROGRAM)
                 && (blk_prot || lock_q);                      // RULE_13
    wire wr_state_ok =
        (st_q == ST_IDLE) ||                                   // RULE_01
        ((st_q == ST_ERASE_SUSP) &&
         (c.cmd == bank_lock_pkg::CMD_PROGRAM) &&
         (c.block != es_block_q));                             // RULE_04

    wire susp_ok = (st_q == ST_PROG) || (st_q == ST_ERASE);   // RULE_03
    wire res_ok  = (st_q == ST_PROG_SUSP) || (st_q == ST_ERASE_SUSP);
    wire prot_ok = (st_q != ST_PROG_SUSP) && !running;        // RULE_22

    logic ok;
    always_comb
    begin
        ok = 1'b0;
        case (c.cmd)
            bank_lock_pkg::CMD_READ_ARRAY,
            bank_lock_pkg::CMD_READ_STATUS,
            bank_lock_pkg::CMD_READ_QUERY,
            bank_lock_pkg::CMD_READ_SIGNATURE:
                ok = rd_ok;                                    // RULE_05
            bank_lock_pkg::CMD_PROG_SETUP,
            bank_lock_pkg::CMD_ERASE_SETUP:
                ok = (st_q == ST_IDLE) || (st_q == ST_ERASE_SUSP);
            bank_lock_pkg::CMD_PROGRAM,
            bank_lock_pkg::CMD_ERASE,
            bank_lock_pkg::CMD_OTP_PROGRAM:
                ok = wr_state_ok && !prot_hit;                 // RULE_10
            bank_lock_pkg::CMD_SUSPEND:
                ok = susp_ok;                                  // RULE_07
            bank_lock_pkg::CMD_RESUME:
                ok = res_ok;                                   // RULE_07
            bank_lock_pkg::CMD_PROTECT,
            bank_lock_pkg::CMD_UNPROTECT:
                ok = prot_ok;                                  // RULE_19
            default:
                ok = 1'b0;
        endcase
    end

    wire take = cmd_valid && ok;
    wire perr = cmd_valid && prot_hit && wr_state_ok;          // RULE_17

    always_comb
    begin
        st_d = st_q;
        if (take)
        begin
            case (c.cmd)
                bank_lock_pkg::CMD_PROGRAM,
                bank_lock_pkg::CMD_OTP_PROGRAM:
                    st_d = (st_q == ST_ERASE_SUSP) ? ST_PROG_IN_ESUSP
                                                   : ST_PROG;
                bank_lock_pkg::CMD_ERASE:
                    st_d = ST_ERASE;
                bank_lock_pkg::CMD_SUSPEND:
                    st_d = (st_q == ST_PROG) ? ST_PROG_SUSP
                                             : ST_ERASE_SUSP;
                bank_lock_pkg::CMD_RESUME:
                    st_d = (st_q == ST_PROG_SUSP) ? ST_PROG
                                                  : ST_ERASE; // RULE_21
                default:
                    st_d = st_q;
            endcase
        end
        else if (op_done)
        begin
            case (st_q)
                ST_PROG, ST_ERASE: st_d = ST_IDLE;
                ST_PROG_IN_ESUSP:  st_d = ST_ERASE_SUSP;
                default:           st_d = st_q;
            endcase
        end
    end

    wire load_op = take && is_write;
    wire to_es   = take && (c.cmd == bank_lock_pkg::CMD_SUSPEND) &&
                   (st_q == ST_ERASE);
    wire from_es = take && (c.cmd == bank_lock_pkg::CMD_RESUME) &&
                   (st_q == ST_ERASE_SUSP);

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_q       <= ST_IDLE;
            op_bank_q  <= bank_lock_pkg::BANK_RESET;
            op_block_q <= bank_lock_pkg::BLOCK_RESET;
            op_word_q  <= 16'h0000;
            op_otp_q   <= 1'b0;
            es_bank_q  <= bank_lock_pkg::BANK_RESET;
            es_block_q <= bank_lock_pkg::BLOCK_RESET;
        end
        else
        begin
            st_q <= st_d;                                      // RULE_23
            if (load_op)
            begin
                op_bank_q  <= c.bank;
                op_block_q <= c.block;
                op_word_q  <= c.word;
                op_otp_q   <= (c.cmd == bank_lock_pkg::CMD_OTP_PROGRAM);
            end
            if (to_es)
            begin
                es_bank_q  <= op_bank_q;
                es_block_q <= op_block_q;
            end
            if (from_es)
            begin
                op_bank_q  <= es_bank_q;
                op_block_q <= es_block_q;
                op_otp_q   <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Protect bits

    genvar g;
    generate
        for (g = 0; g < NUM_BLOCKS; g++)
        begin : g_prot
            wire hit = take && (c.block == KB'(g));
            always_ff @(posedge clk or posedge sys_rst)
            begin
                if (sys_rst)
                    prot_q[g] <= bank_lock_pkg::PROTECT_RESET; // RULE_16
                else if (hit && c.cmd == bank_lock_pkg::CMD_PROTECT)
                    prot_q[g] <= 1'b1;                         // RULE_14
                else if (hit && c.cmd == bank_lock_pkg::CMD_UNPROTECT)
                    prot_q[g] <= 1'b0;                         // RULE_18
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Answer registers

    wire sig_rd = take && (c.cmd == bank_lock_pkg::CMD_READ_SIGNATURE);

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            resp       <= '0;
            prog_busy  <= 1'b0;
            erase_busy <= 1'b0;
            prog_susp  <= 1'b0;
            erase_susp <= 1'b0;
        end
        else
        begin
            resp.accepted      <= take;
            resp.refused       <= cmd_valid && !ok;
            resp.protect_error <= perr;
            resp.read_valid    <= take && is_read &&           // RULE_08
                                  !(running && same_bank && is_arr_rd);
            resp.protect_status_line <= sig_rd && blk_prot;    // RULE_15
            prog_busy  <= (st_d == ST_PROG) || (st_d == ST_PROG_IN_ESUSP);
            erase_busy <= (st_d == ST_ERASE);
            prog_susp  <= (st_d == ST_PROG_SUSP);
            erase_susp <= (st_d == ST_ERASE_SUSP) ||
                          (st_d == ST_PROG_IN_ESUSP);
        end
    end

endmodule

// File: dv/bank_lock_assertions.sv
`timescale 1ns/100ps
module bank_lock_assertions (
    // Clock and reset
    input wire logic                 clk,
    input wire logic                 sys_rst,
    // Commands and engine
    input wire logic                 cmd_valid,
    input wire bank_lock_pkg::cmd_s  cmd_in,
    input wire logic                 op_done,
    input wire logic                 program_supply_lockout_level,
    // Answer and state
    input wire bank_lock_pkg::resp_s resp,
    input wire logic                 prog_busy,
    input wire logic                 erase_busy,
    input wire logic                 prog_susp,
    input wire logic                 erase_susp
);
    wire [3:0] st = {prog_busy, erase_busy, prog_susp, erase_susp};
    wire is_pg = cmd_valid && cmd_in.cmd == bank_lock_pkg::CMD_PROGRAM;
    wire is_er = cmd_valid && cmd_in.cmd == bank_lock_pkg::CMD_ERASE;
    wire is_su = cmd_valid && cmd_in.cmd == bank_lock_pkg::CMD_SUSPEND;
    wire is_re = cmd_valid && cmd_in.cmd == bank_lock_pkg::CMD_RESUME;
    wire is_pr = cmd_valid && (cmd_in.cmd == bank_lock_pkg::CMD_PROTECT ||
                               cmd_in.cmd == bank_lock_pkg::CMD_UNPROTECT);

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_one_answer: assert property (
        cmd_valid |=> resp.accepted != resp.refused)
        else $error("command not answered once");
    a_error_refuses: assert property (
        resp.protect_error |-> resp.refused)
        else $error("error without refusal");
    a_single_op: assert property (
        !(prog_busy && erase_busy))
        else $error("two operations running");
    a_refuse_holds: assert property (
        resp.refused && !$past(op_done) |-> st == $past(st))
        else $error("refused command changed state");
    a_no_prot_psusp: assert property (
        is_pr && prog_susp |=> resp.refused)
        else $error("protect taken in program suspend");
    a_erase_busy_no: assert property (
        is_er && st != 4'h0 |=> resp.refused)
        else $error("erase taken while busy");
    a_lockout_bars: assert property (
        program_supply_lockout_level [*6] ##0 (is_pg && st == 4'h0)
        |=> resp.refused && resp.protect_error)
        else $error("program taken under lockout");
    a_suspend_taken: assert property (
        is_su && prog_busy && !erase_susp && !op_done
        |=> resp.accepted && prog_susp && !prog_busy)
        else $error("program suspend not taken");
    a_resume_erase: assert property (
        is_re && erase_susp && !prog_busy && !op_done
        |=> resp.accepted ##0 erase_busy && !erase_susp)
        else $error("erase resume not taken");

    c_prog_susp: cover property (prog_susp);
    c_nested: cover property (prog_busy && erase_susp);
    c_prot_err: cover property (resp.protect_error);
endmodule

bind bank_lock bank_lock_assertions u_chk (
    .clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
    .cmd_in(cmd_in), .op_done(op_done),
    .program_supply_lockout_level(program_supply_lockout_level),
    .resp(resp), .prog_busy(prog_busy), .erase_busy(erase_busy),
    .prog_susp(prog_susp), .erase_susp(erase_susp)
);

// File: dv/array_engine_model.sv
`timescale 1ns/100ps
module array_engine_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // Engine control
    input  wire logic run_busy,
    input  wire logic hold,
    output logic      op_done
);
    logic [2:0] cnt_q;
    wire        run = run_busy && !hold && !op_done;

    // Finish a running operation after four cycles unless stalled
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst)
        begin
            cnt_q   <= 3'h0;
            op_done <= 1'b0;
        end
        else
        begin
            op_done <= run && cnt_q == 3'h3;
            cnt_q   <= run ? cnt_q + 3'h1 : 3'h0;
        end
endmodule

// File: dv/bank_lock_tb.sv
`timescale 1ns/100ps
module bank_lock_tb;
    logic                 clk       = 1'b0;
    logic                 sys_rst   = 1'b1;
    logic                 cmd_valid = 1'b0;
    bank_lock_pkg::cmd_s  cmd_in    = '0;
    logic                 lockout   = 1'b0;
    logic                 hold      = 1'b1;
    logic                 op_done;
    bank_lock_pkg::resp_s resp;
    bank_lock_pkg::resp_s r;
    logic                 prog_busy;
    logic                 erase_busy;
    logic                 prog_susp;
    logic                 erase_susp;
    logic [63:0]          prot = '1;
    int                   miscompares = 0;
    int                   check_count = 0;

    always #2.5 clk = ~clk;

    bank_lock u_dut (
        .clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
        .cmd_in(cmd_in), .op_done(op_done),
        .program_supply_lockout_level(lockout), .resp(resp),
        .prog_busy(prog_busy), .erase_busy(erase_busy),
        .prog_susp(prog_susp), .erase_susp(erase_susp)
    );

    array_engine_model u_eng (
        .clk(clk), .sys_rst(sys_rst), .run_busy(prog_busy | erase_busy),
        .hold(hold), .op_done(op_done)
    );

    ////////////////////////////////////////////////////////////////////////
    function automatic bank_lock_pkg::resp_s ex(int a, int e = 0,
                                                int v = 0, int p = 0);
        return '{a != 0, a == 0, e != 0, v != 0, p != 0};
    endfunction

    task automatic finish_test();
        $display("Checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk_resp(string what, bank_lock_pkg::resp_s exp);
        check_count++;
        if (r !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, r);
        end
    endtask

    task automatic chk_st(logic [3:0] exp);
        logic [3:0] s;
        s = {prog_busy, erase_busy, prog_susp, erase_susp};
        check_count++;
        if (s !== exp)
        begin
            miscompares++;
            $display("Error state expected %h seen %h", exp, s);
        end
    endtask

    task automatic op(bank_lock_pkg::cmd_e c, logic [5:0] b,
                      bank_lock_pkg::resp_s exp,
                      bank_lock_pkg::space_e sp = bank_lock_pkg::SPACE_ARRAY);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_in    <= '{c, sp, b[5:2], b, 16'($urandom)};
        @(posedge clk);
        cmd_valid <= 1'b0;
        #1 r = resp;
        chk_resp(c.name(), exp);
    endtask

    task automatic sig(logic [5:0] b, logic p);
        op(bank_lock_pkg::CMD_READ_SIGNATURE, b, ex(1'b1, 1'b0, 1'b1, p),
           bank_lock_pkg::SPACE_SIGNATURE);
    endtask

    task automatic run_engine();
        int n;
        @(posedge clk) hold <= 1'b0;
        n = 0;
        do
        begin
            @(posedge clk);
            #1 n++;
        end while ((prog_busy || erase_busy) && n < 40);
        if (n >= 40)
        begin
            miscompares++;
            finish_test();
        end
        hold <= 1'b1;
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        int         k;
        logic [5:0] x;
        logic [5:0] b;
        logic [5:0] o;
        void'($urandom(32'hDD79BE64));
        b = 6'h05;
        o = 6'h21;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (6) @(posedge clk);
        for (int i = 0; i < 64; i++)
            sig(6'(i), 1'b1);
        op(bank_lock_pkg::CMD_PROGRAM, 6'($urandom), ex(0, 1));
        chk_st(4'h0);
        $display("test reset_protect done");
        repeat (60)
        begin
            x = 6'($urandom);
            k = $urandom % 3;
            if (k == 2)
                sig(x, prot[x]);
            else
            begin
                op(k ? bank_lock_pkg::CMD_UNPROTECT
                     : bank_lock_pkg::CMD_PROTECT, x, ex(1));
                prot[x] = (k == 0);
            end
        end
        $display("test random_protect done");
        op(bank_lock_pkg::CMD_UNPROTECT, b, ex(1));
        op(bank_lock_pkg::CMD_UNPROTECT, o, ex(1));
        op(bank_lock_pkg::CMD_PROGRAM, b, ex(1));
        chk_st(4'h8);
        op(bank_lock_pkg::CMD_READ_ARRAY, o, ex(1, 0, 1));
        op(bank_lock_pkg::CMD_ERASE, o, ex(0));
        op(bank_lock_pkg::CMD_PROGRAM, o, ex(0));
        op(bank_lock_pkg::CMD_READ_ARRAY, b, ex(1, 0, 0));
        op(bank_lock_pkg::CMD_READ_STATUS, b, ex(1, 0, 1));
        op(bank_lock_pkg::CMD_SUSPEND, b, ex(1));
        chk_st(4'h2);
        op(bank_lock_pkg::CMD_PROTECT, o, ex(0));
        op(bank_lock_pkg::CMD_PROGRAM, o, ex(0));
        op(bank_lock_pkg::CMD_READ_ARRAY, 6'h04, ex(1, 0, 1));
        op(bank_lock_pkg::CMD_RESUME, b, ex(1));
        run_engine();
        chk_st(4'h0);
        $display("test program_suspend done");
        op(bank_lock_pkg::CMD_ERASE, b, ex(1));
        op(bank_lock_pkg::CMD_SUSPEND, b, ex(1));
        chk_st(4'h1);
        op(bank_lock_pkg::CMD_ERASE, o, ex(0));
        op(bank_lock_pkg::CMD_READ_STATUS, b, ex(1, 0, 1));
        op(bank_lock_pkg::CMD_PROTECT, b, ex(1));
        op(bank_lock_pkg::CMD_PROGRAM, o, ex(1));
        chk_st(4'h9);
        run_engine();
        op(bank_lock_pkg::CMD_RESUME, b, ex(1));
        chk_st(4'h4);
        run_engine();
        chk_st(4'h0);
        op(bank_lock_pkg::CMD_PROGRAM, b, ex(0, 1));
        $display("test erase_suspend done");
        op(bank_lock_pkg::CMD_PROG_SETUP, o, ex(1));
        op(bank_lock_pkg::CMD_READ_ARRAY, 6'h10, ex(1, 0, 1));
        op(bank_lock_pkg::CMD_UNPROTECT, 6'h3D, ex(1));
        op(bank_lock_pkg::CMD_PROGRAM, 6'h3D, ex(1));
        op(bank_lock_pkg::CMD_READ_QUERY, 6'h10, ex(0),
           bank_lock_pkg::SPACE_QUERY);
        op(bank_lock_pkg::CMD_READ_SIGNATURE, 6'h10, ex(0),
           bank_lock_pkg::SPACE_SIGNATURE);
        op(bank_lock_pkg::CMD_READ_ARRAY, 6'h3C, ex(0));
        op(bank_lock_pkg::CMD_READ_ARRAY, 6'h10, ex(1, 0, 1));
        op(bank_lock_pkg::CMD_READ_STATUS, 6'h3D, ex(1, 0, 1));
        run_engine();
        op(bank_lock_pkg::CMD_OTP_PROGRAM, 6'h10, ex(1),
           bank_lock_pkg::SPACE_OTP);
        chk_st(4'h8);
        op(bank_lock_pkg::CMD_READ_ARRAY, 6'h30, ex(0));
        run_engine();
        chk_st(4'h0);
        $display("test dual_limits done");
        @(posedge clk) lockout <= 1'b1;
        repeat (8) @(posedge clk);
        op(bank_lock_pkg::CMD_PROGRAM, o, ex(0, 1));
        op(bank_lock_pkg::CMD_ERASE, o, ex(0, 1));
        @(posedge clk) lockout <= 1'b0;
        repeat (8) @(posedge clk);
        op(bank_lock_pkg::CMD_PROGRAM, o, ex(1));
        run_engine();
        @(posedge clk) sys_rst <= 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (6) @(posedge clk);
        sig(o, 1'b1);
        $display("test lockout_reset done");
        finish_test();
    end
endmodule
